// >>> design/ssfe_pkg.sv
// Constants, types and reset values for the serial frame engine
package ssfe_pkg;

	// ****************************************
	// Widths and formats
	// ****************************************
	localparam int SSFE_DATA_W = 16;
	localparam logic [1:0] SSFE_FMT_SPI = 2'h0;
	localparam logic [1:0] SSFE_FMT_CMDRESP = 2'h2;
	localparam logic [3:0] SSFE_SIZE_MIN = 4'h3;
	localparam logic [4:0] SSFE_BITS_MAX = 5'h10;

	// ****************************************
	// Command-response frame layout, in clocks
	// ****************************************
	localparam logic [4:0] SSFE_CMD_BITS = 5'h08;
	localparam logic [4:0] SSFE_WAIT_CLKS = 5'h01;
	localparam logic [4:0] SSFE_RX_SKIP = SSFE_CMD_BITS + SSFE_WAIT_CLKS;

	// ****************************************
	// Idle pin levels
	// ****************************************
	localparam logic SSFE_FSS_IDLE = 1'b1;
	localparam logic SSFE_TXD_IDLE = 1'b0;
	localparam logic SSFE_CMD_CLK_IDLE = 1'b0;

	// ****************************************
	// Frame state machine
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_GAP = 5'b00010,
		ST_SHIFT = 5'b00100,
		ST_TRAIL = 5'b01000,
		ST_CMD = 5'b10000
	} ssfe_state_t;

	typedef struct packed {
		ssfe_state_t st;
		logic sclk;
		logic fss;
		logic txd;
		logic txoe;
		logic [15:0] sh_tx;
		logic [15:0] sh_rx;
		logic [4:0] cnt;
		logic cap;
		logic tcnt;
		logic done;
		logic pend;
		logic [15:0] rx_data;
		logic rx_valid;
	} ssfe_regs_t;

	localparam ssfe_regs_t SSFE_REGS_RST = '{default: '0, st: ST_IDLE,
		sclk: 1'b1, fss: SSFE_FSS_IDLE};

	// ****************************************
	// Divider state
	// ****************************************
	typedef struct packed {
		logic [6:0] pre;
		logic [7:0] rate;
	} ssfe_div_t;

	localparam ssfe_div_t SSFE_DIV_RST = '{default: '0};

endpackage

// >>> design/ssfe_clkdiv.sv
// Half serial period enable divider for the serial frame engine
`timescale 1ns/10ps
module ssfe_clkdiv
	import ssfe_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Control
	input wire logic i_run,
	input wire logic [7:0] i_prescale,
	input wire logic [7:0] i_rate,
	// Enable out
	output logic o_half_tick
);

	ssfe_div_t q_reg;
	ssfe_div_t q_next;
	logic [6:0] half_pre;
	logic pre_wrap;

	// An odd or zero divisor is out of range; treat an odd one as its even floor, and 0 or 1 as 2
	assign half_pre = (i_prescale[7:1] == 7'h00) ? 7'h01 : i_prescale[7:1];
	assign pre_wrap = (q_reg.pre == half_pre - 7'h01);
	assign o_half_tick = i_run && pre_wrap && (q_reg.rate == i_rate);

	always_comb
	begin
		q_next = q_reg;
		if (!i_run)
		begin
			q_next = SSFE_DIV_RST;
		end
		else if (pre_wrap)
		begin
			q_next.pre = 7'h00;
			q_next.rate = (q_reg.rate == i_rate) ? 8'h00 : q_reg.rate + 8'h01;
		end
		else
		begin
			q_next.pre = q_reg.pre + 7'h01;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			q_reg <= SSFE_DIV_RST;
		else
			q_reg <= q_next;
	end

endmodule

// >>> design/ssfe_engine.sv
// Serial frame engine: full-duplex and command-response master
`timescale 1ns/10ps
module ssfe_engine
	import ssfe_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Configuration
	input wire logic i_port_enable_bit,
	input wire logic i_slave_mode,
	input wire logic i_slave_out_disable,
	input wire logic [7:0] i_prescale_divisor,
	input wire logic [7:0] i_clock_rate_field,
	input wire logic i_clock_phase_bit,
	input wire logic i_clock_polarity_bit,
	input wire logic [1:0] i_frame_format_field,
	input wire logic [3:0] i_data_size_field,
	// Transmit queue head
	input wire logic i_tx_valid,
	input wire logic [15:0] i_tx_data,
	output logic o_tx_pop,
	// Receive queue push
	output logic o_rx_valid,
	output logic [15:0] o_rx_data,
	// Serial pins
	output logic o_serial_clock_pin,
	output logic o_serial_clock_oe,
	output logic o_frame_select_pin,
	output logic o_frame_select_oe,
	output logic o_serial_out_pin,
	output logic o_serial_out_oe,
	input wire logic i_serial_in_pin,
	// Status
	output logic o_busy
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [4:0] frame_bits(input logic [3:0] size);
		frame_bits = (size < SSFE_SIZE_MIN) ? 5'h04 : {1'b0, size} + 5'h01;
	endfunction

	function automatic logic [15:0] left_align(input logic [15:0] v,
		input logic [4:0] n);
		left_align = v << (SSFE_BITS_MAX - n);
	endfunction

	function automatic logic [15:0] keep_low(input logic [15:0] v,
		input logic [4:0] n);
		keep_low = v & ~(16'hFFFF << n);
	endfunction

	ssfe_regs_t q_reg;
	ssfe_regs_t q_next;
	logic half_tick;
	logic load;
	logic more;
	logic is_cmd;
	logic pol;
	logic clock_phase_bit;
	logic [4:0] nbits;
	logic [15:0] rx_shift;
	logic [15:0] word;

	assign is_cmd = (i_frame_format_field == SSFE_FMT_CMDRESP);
	assign pol = i_clock_polarity_bit;
	assign clock_phase_bit = i_clock_phase_bit;
	assign nbits = frame_bits(i_data_size_field);
	assign rx_shift = {q_reg.sh_rx[14:0], i_serial_in_pin};
	assign word = left_align(i_tx_data, nbits);
	// Slave transfers are not started here; the port only answers as master
	assign more = i_port_enable_bit && i_tx_valid && !i_slave_mode;

	// ****************************************
	// Serial rate divider
	// ****************************************
	ssfe_clkdiv u_div (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_run(q_reg.st != ST_IDLE),
		.i_prescale(i_prescale_divisor),
		.i_rate(i_clock_rate_field),
		.o_half_tick(half_tick)
	);

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_comb
	begin
		q_next = q_reg;
		load = 1'b0;
		q_next.rx_valid = 1'b0;
		case (q_reg.st)
			ST_IDLE:
			begin
				q_next.fss = SSFE_FSS_IDLE;
				q_next.txd = SSFE_TXD_IDLE;
				q_next.txoe = 1'b0;
				q_next.sclk = is_cmd ? SSFE_CMD_CLK_IDLE : pol;
				q_next.cnt = 5'h00;
				q_next.done = 1'b0;
				q_next.pend = 1'b0;
				q_next.tcnt = 1'b0;
				if (more)
				begin
					load = 1'b1;
					q_next.fss = 1'b0;
					q_next.txoe = 1'b1;
					q_next.cap = 1'b0;
					if (is_cmd)
					begin
						q_next.txd = i_tx_data[7];
						q_next.sh_tx = {i_tx_data[6:0], 9'h000};
						q_next.st = ST_CMD;
					end
					else
					begin
						q_next.sh_tx = word;
						q_next.st = ST_SHIFT;
					end
				end
			end
			ST_GAP:
			begin
				if (half_tick)
				begin
					load = 1'b1;
					q_next.fss = 1'b0;
					q_next.txoe = 1'b1;
					q_next.sh_tx = word;
					q_next.cap = 1'b0;
					q_next.cnt = 5'h00;
					q_next.st = ST_SHIFT;
				end
			end
			ST_SHIFT:
			begin
				if (half_tick && !q_reg.cap)
				begin
					// Drive slot: clock idle for phase 0, active for phase 1
					q_next.txd = q_reg.sh_tx[15];
					q_next.sh_tx = {q_reg.sh_tx[14:0], 1'b0};
					q_next.sclk = pol ^ clock_phase_bit;
					q_next.cap = 1'b1;
				end
				else if (half_tick)
				begin
					q_next.sh_rx = rx_shift;
					q_next.sclk = !(pol ^ clock_phase_bit);
					q_next.cap = 1'b0;
					q_next.cnt = q_reg.cnt + 5'h01;
					if (q_reg.cnt + 5'h01 == nbits)
					begin
						q_next.rx_data = keep_low(rx_shift, nbits);
						q_next.rx_valid = 1'b1;
						q_next.tcnt = 1'b0;
						q_next.st = ST_TRAIL;
					end
				end
			end
			ST_TRAIL:
			begin
				if (half_tick && !q_reg.tcnt)
				begin
					q_next.sclk = pol;
					q_next.tcnt = 1'b1;
					if (clock_phase_bit && more)
					begin
						// Next word rides on without a select pulse
						load = 1'b1;
						q_next.txd = word[15];
						q_next.sh_tx = {word[14:0], 1'b0};
						q_next.sclk = !pol;
						q_next.cap = 1'b1;
						q_next.cnt = 5'h00;
						q_next.st = ST_SHIFT;
					end
				end
				else if (half_tick)
				begin
					q_next.fss = SSFE_FSS_IDLE;
					q_next.txd = SSFE_TXD_IDLE;
					q_next.txoe = 1'b0;
					q_next.tcnt = 1'b0;
					q_next.pend = 1'b0;
					if (q_reg.pend)
					begin
						q_next.rx_data = keep_low(q_reg.sh_rx, nbits);
						q_next.rx_valid = 1'b1;
					end
					q_next.st = (!is_cmd && !clock_phase_bit && more) ? ST_GAP : ST_IDLE;
				end
			end
			ST_CMD:
			begin
				if (half_tick && !q_reg.sclk)
				begin
					q_next.sclk = 1'b1;
					q_next.cnt = q_reg.cnt + 5'h01;
					// Command and wait clocks take nothing in
					if (q_reg.cnt >= SSFE_RX_SKIP)
						q_next.sh_rx = rx_shift;
					if (q_reg.cnt + 5'h01 == SSFE_RX_SKIP + nbits)
						q_next.done = 1'b1;
				end
				else if (half_tick)
				begin
					q_next.sclk = 1'b0;
					if (q_reg.done && more)
					begin
						load = 1'b1;
						q_next.rx_data = keep_low(q_reg.sh_rx, nbits);
						q_next.rx_valid = 1'b1;
						q_next.txd = i_tx_data[7];
						q_next.sh_tx = {i_tx_data[6:0], 9'h000};
						q_next.cnt = 5'h00;
						q_next.done = 1'b0;
					end
					else if (q_reg.done)
					begin
						q_next.done = 1'b0;
						q_next.pend = 1'b1;
						q_next.tcnt = 1'b1;
						q_next.st = ST_TRAIL;
					end
					else
					begin
						// Zeros follow the command, so the line rests low
						q_next.txd = q_reg.sh_tx[15];
						q_next.sh_tx = {q_reg.sh_tx[14:0], 1'b0};
					end
				end
			end
			default:
			begin
				q_next = SSFE_REGS_RST;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			q_reg <= SSFE_REGS_RST;
		else
			q_reg <= q_next;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_tx_pop = load;
	assign o_rx_valid = q_reg.rx_valid;
	assign o_rx_data = q_reg.rx_data;
	assign o_serial_clock_pin = q_reg.sclk;
	assign o_serial_clock_oe = !i_slave_mode;
	assign o_frame_select_pin = q_reg.fss;
	assign o_frame_select_oe = !i_slave_mode;
	assign o_serial_out_pin = q_reg.txd;
	assign o_serial_out_oe = q_reg.txoe && !i_slave_out_disable;
	assign o_busy = (q_reg.st != ST_IDLE);

	// ****************************************
	// Checks
	// ****************************************
	logic [15:0] gap_cnt;
	logic [15:0] half_len;

	assign half_len = 16'(i_prescale_divisor[7:1]) *
		(16'(i_clock_rate_field) + 16'h0001);

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || !o_busy || half_tick)
			gap_cnt <= 16'h0000;
		else
			gap_cnt <= gap_cnt + 16'h0001;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sequence s_stay_idle;
		q_reg.st == ST_IDLE && $past(q_reg.st) == ST_IDLE &&
			$stable(pol) && $stable(i_frame_format_field);
	endsequence

	sequence s_start;
		q_reg.st == ST_IDLE && more;
	endsequence

	property p_idle_spi;
		s_stay_idle and (!is_cmd && pol) |->
			o_serial_clock_pin && o_frame_select_pin && !o_serial_out_pin;
	endproperty
	a_idle_spi: assert property (p_idle_spi)
		else $error("idle levels wrong for high polarity");

	property p_idle_oe;
		q_reg.st == ST_IDLE |-> o_serial_clock_oe == !i_slave_mode;
	endproperty
	a_idle_oe: assert property (p_idle_oe)
		else $error("clock driver enable wrong while idle");

	property p_start;
		s_start |=> !o_frame_select_pin && q_reg.txoe;
	endproperty
	a_start: assert property (p_start)
		else $error("transfer did not start");

	// A one-cycle half period moves the clock again after one cycle
	property p_first_edge;
		q_reg.st == ST_SHIFT && q_reg.cap && half_tick && !clock_phase_bit &&
			half_len != 16'h0001 |=>
			o_serial_clock_pin == !pol ##1 o_serial_clock_pin == !pol;
	endproperty
	a_first_edge: assert property (p_first_edge)
		else $error("clock not active on capture, phase 0");

	property p_end;
		q_reg.st == ST_TRAIL && q_reg.tcnt && half_tick |=>
			o_frame_select_pin && !q_reg.txoe;
	endproperty
	a_end: assert property (p_end)
		else $error("frame select did not return high");

	property p_gap;
		q_reg.st == ST_GAP |-> o_frame_select_pin;
	endproperty
	a_gap: assert property (p_gap)
		else $error("no select pulse between words");

	property p_second_edge;
		q_reg.st == ST_SHIFT && !q_reg.cap && half_tick && clock_phase_bit |=>
			o_serial_clock_pin == !pol;
	endproperty
	a_second_edge: assert property (p_second_edge)
		else $error("clock not active on drive, phase 1");

	property p_hold_low;
		q_reg.st == ST_TRAIL && !q_reg.tcnt && half_tick && clock_phase_bit && more
			&& !is_cmd |=> !o_frame_select_pin [*2];
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("select rose between phase 1 words");

	property p_cmd_start;
		s_start and is_cmd |=>
			!o_frame_select_pin && o_serial_out_pin == $past(i_tx_data[7]);
	endproperty
	a_cmd_start: assert property (p_cmd_start)
		else $error("command MSB not presented at select fall");

	property p_cmd_low;
		q_reg.st == ST_CMD |-> !o_frame_select_pin;
	endproperty
	a_cmd_low: assert property (p_cmd_low)
		else $error("select rose inside command frame");

	property p_cmd_quiet;
		q_reg.st == ST_CMD && q_reg.cnt < SSFE_RX_SKIP |=>
			$stable(q_reg.sh_rx);
	endproperty
	a_cmd_quiet: assert property (p_cmd_quiet)
		else $error("receive shifter moved during command");

	property p_rate;
		half_tick |-> gap_cnt + 16'h0001 == half_len;
	endproperty
	a_rate: assert property (p_rate)
		else $error("half period length wrong");

	property p_width;
		o_rx_valid |-> keep_low(o_rx_data, nbits) == o_rx_data;
	endproperty
	a_width: assert property (p_width)
		else $error("received word wider than frame");

endmodule

// >>> dv/ssfe_slave_model.sv
// Off-chip serial slave model facing the frame engine pins
`timescale 1ns/10ps
module ssfe_slave_model (
	// Clock
	input wire logic i_clk_sys,
	// Engine pins
	input wire logic i_sclk,
	input wire logic i_fss,
	input wire logic i_mosi,
	// Mode and response
	input wire logic i_pol,
	input wire logic i_pha,
	input wire logic i_cr,
	input wire logic [4:0] i_n,
	input wire logic [15:0] i_resp,
	// Slave outputs
	output logic o_miso,
	output logic [15:0] o_got
);
	logic sclk_q = 1'b1;
	logic fss_q = 1'b1;
	logic on = 1'b0;
	logic last = 1'b0;
	logic lead;
	logic trail;
	logic [15:0] sh = 16'h0000;
	logic [4:0] cnt = 5'h00;
	logic [4:0] rises = 5'h00;
	// Released line toggles so a stale bit can never pass for data
	assign o_miso = (!i_fss && on) ? sh[15] : !last;
	always @(negedge i_clk_sys)
	begin
		lead = (i_sclk != sclk_q) && (i_sclk != (i_cr ? 1'b0 : i_pol));
		trail = (i_sclk != sclk_q) && !lead;
		sclk_q <= i_sclk;
		fss_q <= i_fss;
		last <= o_miso;
		if (fss_q && !i_fss)
		begin
			sh <= i_resp << (16 - i_n);
			on <= !i_pha && !i_cr;
			cnt <= 5'h00;
			rises <= 5'h00;
			o_got <= 16'h0000;
		end
		else if (i_cr)
		begin
			if (lead)
				rises <= rises + 5'h01;
			if (lead && rises < 5'h08)
				o_got <= {o_got[14:0], i_mosi};
			if (trail && rises == 5'h09 + i_n)
			begin
				rises <= 5'h00;
				on <= 1'b0;
				sh <= i_resp << (16 - i_n);
			end
			else if (trail && rises >= 5'h09)
			begin
				if (on)
					sh <= sh << 1;
				on <= 1'b1;
			end
		end
		else
		begin
			if (i_pha ? trail : lead)
				o_got <= {o_got[14:0], i_mosi};
			if ((i_pha ? lead : trail) && !on)
				on <= 1'b1;
			else if ((i_pha ? lead : trail) && i_pha && cnt == i_n - 5'h01)
			begin
				sh <= i_resp << (16 - i_n);
				cnt <= 5'h00;
			end
			else if (i_pha ? lead : trail)
			begin
				sh <= sh << 1;
				cnt <= cnt + 5'h01;
			end
		end
	end
endmodule

// >>> dv/ssfe_engine_bench.sv
// Self-checking bench for the serial frame engine
`timescale 1ns/10ps
module ssfe_engine_bench
	import ssfe_pkg::*;
;
	localparam int LIM = 40000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b0;
	logic slv = 1'b0;
	logic sod = 1'b0;
	logic pha = 1'b0;
	logic pol = 1'b1;
	logic cr = 1'b0;
	logic [1:0] fmt = 2'h0;
	logic [3:0] size = 4'h7;
	logic [7:0] pre = 8'h02;
	logic [7:0] rate = 8'h01;
	logic tx_valid = 1'b0;
	logic [15:0] tx_data = 16'h0000;
	logic tx_pop, rx_valid, sclk, sclk_oe, fss, fss_oe, sout, sout_oe;
	logic sin, busy, sclk_d, fss_d;
	logic [15:0] rx_data, got, ev, et;
	logic [15:0] resp = 16'h0000;
	logic [15:0] wmask = 16'hFFFF;
	logic [4:0] nb = 5'h08;
	logic [15:0] txq[$];
	logic [15:0] exp_rx[$];
	logic [15:0] exp_tx[$];
	int n_mismatch = 0;
	int compares = 0;
	int n_rise = 0;
	int since = 0;
	int gap = 0;
	int seed = 44;
	always #20 clk = ~clk;
	ssfe_engine uut (.i_clk_sys(clk), .i_rst(rst), .i_port_enable_bit(en),
		.i_slave_mode(slv), .i_slave_out_disable(sod),
		.i_prescale_divisor(pre), .i_clock_rate_field(rate),
		.i_clock_phase_bit(pha), .i_clock_polarity_bit(pol),
		.i_frame_format_field(fmt), .i_data_size_field(size),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_pop(tx_pop),
		.o_rx_valid(rx_valid), .o_rx_data(rx_data),
		.o_serial_clock_pin(sclk), .o_serial_clock_oe(sclk_oe),
		.o_frame_select_pin(fss), .o_frame_select_oe(fss_oe),
		.o_serial_out_pin(sout), .o_serial_out_oe(sout_oe),
		.i_serial_in_pin(sin), .o_busy(busy));
	ssfe_slave_model peer (.i_clk_sys(clk), .i_sclk(sclk), .i_fss(fss),
		.i_mosi(sout), .i_pol(pol), .i_pha(pha), .i_cr(cr), .i_n(nb),
		.i_resp(resp), .o_miso(sin), .o_got(got));
	// ****************************************
	// Queue head, pin timing and result watcher
	// ****************************************
	always @(negedge clk)
	begin
		tx_valid <= txq.size() != 0;
		tx_data <= (txq.size() != 0) ? txq[0] : 16'h0000;
		sclk_d <= sclk;
		fss_d <= fss;
		since <= (sclk !== sclk_d) ? 1 : since + 1;
		if (fss === 1'b1 && fss_d === 1'b0)
		begin
			gap <= since;
			n_rise <= n_rise + 1;
		end
	end
	always @(posedge clk)
		if (tx_pop === 1'b1 && txq.size() != 0)
			void'(txq.pop_front());
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] s);
		compares++;
		if (e !== s)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic guard(input int t);
		if (t >= LIM)
		begin
			n_mismatch++;
			stop_test();
		end
	endtask
	initial
	forever
	begin
		@(negedge clk);
		if (rx_valid === 1'b1 && exp_rx.size() == 0)
			chk("rx_extra", 16'h0000, 16'hFFFF);
		else if (rx_valid === 1'b1)
		begin
			ev = exp_rx.pop_front();
			et = exp_tx.pop_front();
			chk("rx_data", ev, rx_data);
			repeat (2) @(negedge clk);
			chk("tx_bits", et, got & wmask);
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic burst(input logic [1:0] f, input logic p, input logic h,
		input logic [3:0] s, input logic [7:0] d, input logic [7:0] r,
		input int nw);
		int k;
		int t;
		logic l;
		logic [15:0] w;
		int base;
		@(negedge clk);
		en = 1'b0;
		@(negedge clk);
		slv = 1'b0;
		fmt = f;
		pol = p;
		pha = h;
		size = s;
		pre = d;
		rate = r;
		cr = (f == SSFE_FMT_CMDRESP);
		nb = {1'b0, s} + 5'h01;
		wmask = cr ? 16'h00FF : 16'hFFFF >> (16 - nb);
		resp = 16'($random(seed));
		base = n_rise;
		@(negedge clk);
		en = 1'b1;
		for (k = 0; k < nw; k++)
		begin
			w = 16'($random(seed));
			txq.push_back(w & wmask);
			exp_tx.push_back(w & wmask);
			exp_rx.push_back(resp & (16'hFFFF >> (16 - nb)));
		end
		for (t = 0; fss !== 1'b0 && t < LIM; t++)
			@(negedge clk);
		guard(t);
		chk("start_oe", 16'h0001, {15'h0, sout_oe});
		for (t = 0; sclk === (cr ? 1'b0 : p) && t < LIM; t++)
			@(negedge clk);
		guard(t);
		l = sclk;
		for (t = 0; sclk === l && t < LIM; t++)
			@(negedge clk);
		chk("half_period", 16'((d >> 1) * (r + 1)), 16'(t));
		for (t = 0; (txq.size() != 0 || busy !== 1'b0) && t < LIM; t++)
			@(negedge clk);
		guard(t);
		repeat (4) @(negedge clk);
		chk("fss_rises", 16'((!cr && !h) ? nw : 1),
			16'(n_rise - base));
		chk("fss_gap", 16'((d >> 1) * (r + 1) * ((h && !cr) ? 2 : 1)),
			16'(gap));
		chk("idle_clk", {15'h0, cr ? 1'b0 : p}, {15'h0, sclk});
		chk("idle_pins", 16'h0004, {13'h0, fss, sout, sout_oe});
		chk("clk_oe", 16'h0001, {15'h0, sclk_oe});
		chk("rx_left", 16'h0000, 16'(exp_rx.size()));
	endtask
	initial
	begin
		int k;
		logic [15:0] v;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		burst(SSFE_FMT_SPI, 1'b1, 1'b0, 4'h7, 8'h02, 8'h03, 2);
		burst(SSFE_FMT_SPI, 1'b1, 1'b1, 4'hF, 8'h02, 8'h02, 2);
		burst(SSFE_FMT_SPI, 1'b1, 1'b0, 4'h3, 8'h04, 8'h01, 1);
		burst(SSFE_FMT_SPI, 1'b1, 1'b1, 4'h3, 8'h02, 8'h01, 1);
		burst(SSFE_FMT_CMDRESP, 1'b1, 1'b0, 4'h3, 8'h02, 8'h02, 1);
		burst(SSFE_FMT_CMDRESP, 1'b1, 1'b0, 4'hF, 8'h02, 8'h01, 2);
		for (k = 0; k < 4; k++)
		begin
			v = 16'($random(seed));
			burst(SSFE_FMT_SPI, 1'b1, v[9], 4'h3 + 4'(v[3:0] % 13),
				v[5] ? 8'h04 : 8'h02, {5'h00, v[8:6]} | 8'h01,
				1 + k % 2);
		end
		burst(SSFE_FMT_SPI, 1'b1, 1'b0, 4'h7, 8'hFE, 8'h00, 1);
		burst(SSFE_FMT_SPI, 1'b1, 1'b0, 4'h7, 8'h02, 8'h00, 2);
		burst(SSFE_FMT_SPI, 1'b1, 1'b1, 4'h7, 8'h02, 8'hFF, 1);
		// Both slave roles: output enabled, then output disabled
		for (k = 0; k < 2; k++)
		begin
			@(negedge clk);
			en = 1'b0;
			@(negedge clk);
			slv = 1'b1;
			sod = k[0];
			txq = '{16'h00A5};
			@(negedge clk);
			en = 1'b1;
			repeat (30) @(negedge clk);
			chk("slave_pop", 16'h0001, 16'(txq.size()));
			chk("slave_oe", 16'h0000,
				{13'h0, sclk_oe, fss_oe, sout_oe});
		end
		txq.delete();
		stop_test();
	end
endmodule
